// *** logic/spo_defines.vh ***
// Constants for the stack pop and OR execution block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SPO_DEFINES_VH
`define SPO_DEFINES_VH
`define SPO_SP_HIGH_ADDR 8'hD8
`define SPO_SP_LOW_ADDR 8'hD9
`define SPO_OP_POP_DIRECT 8'h50
`define SPO_OP_POP_INDIRECT 8'h51
`define SPO_OP_USER_POP_DEC 8'h92
`define SPO_OP_OR_RR 8'h44
`define SPO_OP_OR_RIR 8'h45
`define SPO_OP_OR_RIM 8'h46
`define SPO_EXEC_CYCLES 4'h8
`define SPO_FLAG_C 7
`define SPO_FLAG_Z 6
`define SPO_FLAG_S 5
`define SPO_FLAG_V 4
`define SPO_SIGN_BIT 7
`endif

// *** logic/spo_regfile.v ***
// Register file memory of 256 bytes with one registered read port and one write port.
// Assumes a single clock; read data appear one cycle after the read address.
`timescale 1ns/1ps
module spo_regfile #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire clk_i,
  input wire ce_i,
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Memory contents have no reset, as in a real register file.
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // spo_regfile

// *** logic/spo_core.v ***
// Execution unit for system stack pop, user stack pop with decrement, and logical OR.
// Assumes instructions arrive decoded to opcode and operand bytes with a one-cycle start pulse.
//
// Contract
// - System pop reads the byte at the stack pointer into the destination.
// - System pop then raises the stack pointer by exactly one.
// - Stack pointer is registers D8 (high) and D9 (low), incremented as 16 bits.
// - User pop copies the byte addressed by the user pointer into the destination.
// - User pointer is a general register named by the indirect source operand.
// - User pop then lowers the user pointer by one and writes it back.
// - Both pops leave all condition flags unchanged.
// - OR stores destination OR source bitwise into the destination.
// - OR clears V, sets S from bit 7, Z on zero; C, D, H kept.
`timescale 1ns/1ps
`include "spo_defines.vh"
module spo_core #(
  parameter EXEC_CYCLES = 8
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire ce_i,
  input wire start_i,
  input wire [7:0] opcode_i,
  input wire [7:0] dst_i,
  input wire [7:0] src_i,
  output wire busy_o,
  output reg done_o,
  output reg illegal_o,
  output reg [7:0] flags_o,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_RD1 = 3'h1;
  localparam ST_RD2 = 3'h2;
  localparam ST_RD3 = 3'h3;
  localparam ST_WR1 = 3'h4;
  localparam ST_WR2 = 3'h5;
  localparam ST_WR3 = 3'h6;
  localparam ST_WAIT = 3'h7;

  reg [2:0] state_q;
  reg [7:0] op_q;
  reg [7:0] dst_q;
  reg [7:0] src_q;
  reg [7:0] data_q;
  reg [7:0] ptr_q;
  reg [7:0] sph_q;
  reg [7:0] spl_q;
  reg [3:0] cnt_q;
  reg [7:0] raddr;
  reg we;
  reg [7:0] waddr;
  reg [7:0] wdata;
  reg rd_pend_q;
  reg sp_sel_q;
  reg [7:0] sp_rd_q;
  wire [7:0] rdata;

  // True for opcodes this block executes.
  function known_op;
    input [7:0] op;
    begin
      known_op = (op == `SPO_OP_POP_DIRECT) || (op == `SPO_OP_POP_INDIRECT) ||
                 (op == `SPO_OP_USER_POP_DEC) || (op == `SPO_OP_OR_RR) ||
                 (op == `SPO_OP_OR_RIR) || (op == `SPO_OP_OR_RIM);
    end
  endfunction

  // True for the indirect OR form and the user pop, whose source register holds a pointer that must be fetched.
  function src_indirect;
    input [7:0] op;
    begin
      src_indirect = (op == `SPO_OP_OR_RIR) || (op == `SPO_OP_USER_POP_DEC);
    end
  endfunction

  wire [15:0] sp_next = {sph_q, spl_q} + 16'h0001;
  // The indirect OR form has its destination value still on the file's read port when it writes.
  wire [7:0] or_res = data_q | ((op_q == `SPO_OP_OR_RIR) ? rdata : ptr_q);
  assign busy_o = (state_q != ST_IDLE);

  // Read data stand only in the cycle after the strobe, because the file's output is already a register.
  always @* begin
    reg_rdata_o = 8'h00;
    if (rd_pend_q) begin
      reg_rdata_o = sp_sel_q ? sp_rd_q : rdata;
    end
  end

  spo_regfile #(.AW(8), .DW(8)) u_rf (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .raddr_i(raddr),
    .rdata_o(rdata),
    .we_i(we),
    .waddr_i(waddr),
    .wdata_i(wdata)
  );

  // Read address and write port steering per state; bus accesses use idle slots only.
  always @* begin
    raddr = reg_addr_i;
    we = 1'b0;
    waddr = reg_addr_i;
    wdata = reg_wdata_i;
    case (state_q)
      ST_IDLE: begin
        we = reg_wr_i && (reg_addr_i != `SPO_SP_HIGH_ADDR) && (reg_addr_i != `SPO_SP_LOW_ADDR);
      end
      ST_RD1: begin
        if (op_q == `SPO_OP_POP_DIRECT || op_q == `SPO_OP_POP_INDIRECT) begin
          raddr = spl_q; // Low byte addresses the on-chip stack.
        end else if (src_indirect(op_q)) begin
          raddr = src_q;
        end else begin
          raddr = src_q;
        end
      end
      ST_RD2: begin
        if (op_q == `SPO_OP_POP_INDIRECT) begin
          raddr = dst_q;
        end else if (op_q == `SPO_OP_USER_POP_DEC) begin
          raddr = rdata; // The pointer value arrives from the previous read.
        end else if (op_q == `SPO_OP_OR_RIR) begin
          raddr = rdata;
        end else begin
          raddr = dst_q;
        end
      end
      ST_RD3: begin
        raddr = dst_q;
      end
      ST_WR1: begin
        we = 1'b1;
        waddr = ptr_q;
        wdata = data_q;
        if (op_q == `SPO_OP_USER_POP_DEC) begin
          waddr = dst_q; // The pointer copy in ptr_q is already lowered here.
        end
        if (op_q == `SPO_OP_OR_RR || op_q == `SPO_OP_OR_RIR || op_q == `SPO_OP_OR_RIM) begin
          waddr = dst_q;
          wdata = or_res;
        end
      end
      ST_WR2: begin
        we = (op_q == `SPO_OP_USER_POP_DEC);
        waddr = src_q;
        wdata = ptr_q;
      end
      default: begin
        raddr = reg_addr_i;
      end
    endcase
  end

  // Sequencer: each pop spends exactly SPO_EXEC_CYCLES cycles from start to done, whatever EXEC_CYCLES is set to.
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      op_q <= 8'h00;
      dst_q <= 8'h00;
      src_q <= 8'h00;
      data_q <= 8'h00;
      ptr_q <= 8'h00;
      sph_q <= 8'h00;
      spl_q <= 8'h00;
      cnt_q <= 4'h0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      flags_o <= 8'h00;
      rd_pend_q <= 1'b0;
      sp_sel_q <= 1'b0;
      sp_rd_q <= 8'h00;
    end else if (ce_i) begin
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      rd_pend_q <= reg_rd_i && (state_q == ST_IDLE);
      sp_sel_q <= 1'b0;
      if (reg_rd_i && state_q == ST_IDLE && reg_addr_i == `SPO_SP_HIGH_ADDR) begin
        sp_sel_q <= 1'b1;
        sp_rd_q <= sph_q;
      end
      if (reg_rd_i && state_q == ST_IDLE && reg_addr_i == `SPO_SP_LOW_ADDR) begin
        sp_sel_q <= 1'b1;
        sp_rd_q <= spl_q;
      end
      if (state_q != ST_IDLE) begin
        cnt_q <= cnt_q + 4'h1;
      end
      case (state_q)
        ST_IDLE: begin
          if (reg_wr_i && reg_addr_i == `SPO_SP_HIGH_ADDR) begin
            sph_q <= reg_wdata_i;
          end
          if (reg_wr_i && reg_addr_i == `SPO_SP_LOW_ADDR) begin
            spl_q <= reg_wdata_i;
          end
          if (start_i && !reg_wr_i && !reg_rd_i) begin
            if (known_op(opcode_i)) begin
              op_q <= opcode_i;
              dst_q <= dst_i;
              src_q <= src_i;
              cnt_q <= 4'h1;
              state_q <= ST_RD1;
            end else begin
              illegal_o <= 1'b1;
            end
          end
        end
        ST_RD1: state_q <= ST_RD2;
        ST_RD2: begin
          data_q <= rdata;
          if (op_q == `SPO_OP_OR_RIM) begin
            data_q <= src_q;
          end
          state_q <= ST_RD3;
        end
        ST_RD3: begin
          ptr_q <= dst_q;
          if (op_q == `SPO_OP_POP_INDIRECT) begin
            ptr_q <= rdata;
          end
          if (op_q == `SPO_OP_USER_POP_DEC || op_q == `SPO_OP_OR_RIR) begin
            data_q <= rdata;
          end
          if (op_q == `SPO_OP_USER_POP_DEC) begin
            ptr_q <= data_q - 8'h01; // The pointer value was latched one cycle earlier.
          end
          if (op_q == `SPO_OP_OR_RR || op_q == `SPO_OP_OR_RIM) begin
            ptr_q <= rdata;
          end
          state_q <= ST_WR1;
        end
        ST_WR1: begin
          if (op_q == `SPO_OP_POP_DIRECT || op_q == `SPO_OP_POP_INDIRECT) begin
            sph_q <= sp_next[15:8];
            spl_q <= sp_next[7:0];
          end
          if (op_q == `SPO_OP_OR_RR || op_q == `SPO_OP_OR_RIR || op_q == `SPO_OP_OR_RIM) begin
            flags_o[`SPO_FLAG_V] <= 1'b0;
            flags_o[`SPO_FLAG_S] <= or_res[`SPO_SIGN_BIT];
            flags_o[`SPO_FLAG_Z] <= (or_res == 8'h00);
          end
          // Pops never touch flags_o.
          state_q <= ST_WR2;
        end
        ST_WR2: state_q <= ST_WAIT;
        default: begin
          if (cnt_q >= `SPO_EXEC_CYCLES - 4'h1) begin
            done_o <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule // spo_core

// *** verification/spo_core_sva.sv ***
// Checker of the stack pop and OR unit, bound to the top module's ports.
// Assumes ce_i stays high and that strobes never share a cycle with a start pulse.
`timescale 1ns/1ps
module spo_chk #(
  parameter EXEC_CYCLES = 8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] dst_i,
  input wire logic [7:0] src_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic illegal_o,
  input wire logic [7:0] flags_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o
);
  // A start is only taken when idle and free of strobes, so the classes ignore the refused ones.
  wire go = start_i && ce_i && !busy_o && !reg_wr_i && !reg_rd_i;
  wire pop = go && (opcode_i == 8'h50 || opcode_i == 8'h51 || opcode_i == 8'h92);
  wire run = go && (pop || (opcode_i >= 8'h44 && opcode_i <= 8'h46));
  wire bad = go && !run;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_time; pop |-> ##[7:8] done_o; endproperty
  a_time: assert property (p_time) else $error("pop length");
  property p_busy; run |=> busy_o; endproperty
  a_busy: assert property (p_busy) else $error("busy missing");
  property p_done; done_o |=> !done_o && !busy_o; endproperty
  a_done: assert property (p_done) else $error("done not single");
  property p_keep; pop |=> $stable(flags_o) [*8]; endproperty
  a_keep: assert property (p_keep) else $error("pop moved flags");
  property p_orf; $changed(flags_o) |-> !flags_o[4] && flags_o[7] == $past(flags_o[7]); endproperty
  a_orf: assert property (p_orf) else $error("overflow or carry");
  property p_zs; !(flags_o[6] && flags_o[5]); endproperty
  a_zs: assert property (p_zs) else $error("zero with sign");
  property p_ill; bad |-> ##[1:8] illegal_o; endproperty
  a_ill: assert property (p_ill) else $error("illegal missing");
  property p_rw; reg_wr_i && !busy_o ##2 reg_rd_i && reg_addr_i == $past(reg_addr_i, 2)
    |=> reg_rdata_o == $past(reg_wdata_i, 3); endproperty
  a_rw: assert property (p_rw) else $error("readback");
endmodule // spo_chk

bind spo_core spo_chk #(.EXEC_CYCLES(EXEC_CYCLES)) chk_u (.*);

// *** verification/spo_tb.sv ***
// Self-checking bench of the stack pop and OR unit over its register port.
// Assumes the checker file is compiled alongside; ce_i is held high throughout.
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic start_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] opcode_i = 8'h00, dst_i = 8'h00, src_i = 8'h00, reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  wire busy_o, done_o, illegal_o;
  wire [7:0] flags_o, reg_rdata_o;
  int fails = 0;
  int num_checks = 0;
  int lat = 0;
  logic saw_ill = 1'b0;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED at %0t: got %h, expected %h", $time, a, e); end end
  spo_core #(.EXEC_CYCLES(8)) dut_u (.*);
  // Free-running 25 MHz clock.
  initial forever #20 clk_i = ~clk_i;
  // Bus tasks hold each strobe for exactly one cycle; read data are sampled in the following cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    `CHK(reg_rdata_o, e)
  endtask
  // One instruction; the wait is bounded so a silent unit cannot hang the run.
  task automatic op(input logic [7:0] o, input logic [7:0] d, input logic [7:0] s);
    @(posedge clk_i);
    start_i <= 1'b1;
    opcode_i <= o;
    dst_i <= d;
    src_i <= s;
    @(posedge clk_i);
    start_i <= 1'b0;
    lat = 0;
    repeat (12) begin
      @(negedge clk_i);
      lat++;
      saw_ill = (illegal_o === 1'b1);
      if (done_o === 1'b1 || saw_ill) break;
    end
    // A run-out leaves lat at the loop limit, so a silent unit counts as a mismatch.
    `CHK(lat, (o == 8'hFF) ? 1 : 8)
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence: OR forms, pointer carry and wrap, then an unknown opcode.
  initial begin
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(8'hD8, 8'h00);
    rd(8'hD9, 8'h00);
    wr(8'h10, 8'h15);
    wr(8'h11, 8'h2A);
    op(8'h44, 8'h10, 8'h11);
    rd(8'h10, 8'h3F);
    `CHK(flags_o, 8'h00)
    wr(8'h20, 8'h28);
    wr(8'h28, 8'h8A);
    wr(8'h21, 8'h37);
    op(8'h45, 8'h21, 8'h20);
    rd(8'h21, 8'hBF);
    `CHK(flags_o, 8'h20)
    op(8'h46, 8'h20, 8'h02);
    rd(8'h20, 8'h2A);
    wr(8'h30, 8'h00);
    op(8'h46, 8'h30, 8'h00);
    `CHK(flags_o, 8'h40)
    wr(8'hD9, 8'hFB);
    rd(8'hD9, 8'hFB);
    wr(8'hFB, 8'h55);
    op(8'h50, 8'h40, 8'h00);
    rd(8'h40, 8'h55);
    rd(8'hD9, 8'hFC);
    `CHK(flags_o, 8'h40)
    // Low byte at its top value makes the increment carry into the high byte.
    wr(8'hD8, 8'h12);
    wr(8'hD9, 8'hFF);
    wr(8'hFF, 8'h77);
    op(8'h50, 8'h41, 8'h00);
    rd(8'h41, 8'h77);
    rd(8'hD8, 8'h13);
    rd(8'hD9, 8'h00);
    wr(8'h00, 8'h9C);
    wr(8'h42, 8'h43);
    op(8'h51, 8'h42, 8'h00);
    rd(8'h43, 8'h9C);
    rd(8'hD9, 8'h01);
    wr(8'h50, 8'h62);
    wr(8'h62, 8'h6F);
    op(8'h92, 8'h52, 8'h50);
    rd(8'h52, 8'h6F);
    rd(8'h50, 8'h61);
    wr(8'h51, 8'h00);
    op(8'h92, 8'h53, 8'h51);
    rd(8'h53, 8'h9C);
    rd(8'h51, 8'hFF);
    `CHK(flags_o, 8'h40)
    op(8'hFF, 8'h00, 8'h00);
    `CHK(saw_ill, 1'b1)
    finish_test();
  end
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    #(40 * 5000);
    fails++;
    finish_test();
  end
endmodule // testbench
